// ===== include/bcb_cfg.svh
`ifndef BCB_CFG_SVH
`define BCB_CFG_SVH
// Function
// RULE1: file bit clear (prefix 1010 1001) zeroes one memory bit, flags untouched.
// RULE2: file address spans 0..8191 bytes, even 0..8190 for words.
// RULE3: bit 0 is the lsb; top bit 7 for bytes, 15 for words.
// RULE4: software gives aligned word addresses and byte bit numbers 0..7.
// RULE5: register bit clear (prefix 1010 0001) byte-select: 0 word, 1 byte.
// RULE6: register form takes direct or five indirect modes, sixteen registers.
// RULE7: enhanced core extends indirect addresses with the data page register.
// RULE8: both bit clears are one word and finish in one cycle.
// RULE9: relative branch (prefix 0011 0111) loads pc+2 plus twice the offset.
// RULE10: branch offset is signed, -32768 to +32767 words.
// RULE11: relative branch takes two cycles, four on the enhanced core.
// RULE12: computed branch adds twice the register, 17-bit sign-extended, then a nop.
// RULE13: computed branch pattern fixed, register in low nibble; 2 or 4 cycles.
// RULE14: carry branch (prefix 0011 0001) branches only when carry is one.
// RULE15: a taken conditional branch runs a nop in an added cycle.
// RULE16: carry branch offset is a 16-bit signed word count from pc+2.
// RULE17: conditional branch: one cycle not taken, two or four when taken.
// RULE18: pointer modification steps one for bytes, two for words.

// ----------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------
`define BCB_OP_FBCLR      8'ha9
`define BCB_OP_WBCLR      8'ha1
`define BCB_OP_BRA        8'h37
`define BCB_OP_BRAC       8'h31
`define BCB_OP_CBR_ORIG   20'h01600
`define BCB_OP_CBR_ENH    20'h01060
`define BCB_FADDR_MAX     13'h1fff
// ----------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------
`define BCB_BR_CYC_ORIG   3'h2
`define BCB_BR_CYC_ENH    3'h4
`endif

// ===== include/bcb_pkg.sv
package bcb_pkg;
    typedef enum logic [2:0] {
        BCB_AM_DIRECT  = 3'h0,
        BCB_AM_IND     = 3'h1,
        BCB_AM_POSTDEC = 3'h2,
        BCB_AM_POSTINC = 3'h3,
        BCB_AM_PREDEC  = 3'h4,
        BCB_AM_PREINC  = 3'h5
    } bcb_amode_type;

    // data memory request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [23:0] addr;
        logic        byte_op;
        logic [15:0] wdata;
    } bcb_mem_req_type;

    // working register write
    typedef struct packed {
        logic        we;
        logic [3:0]  sel;
        logic [15:0] data;
    } bcb_wreg_wr_type;
endpackage

// ===== rtl/bcb_bit_clr.sv
`timescale 1ns/10ps
`include "bcb_cfg.svh"
module bcb_bit_clr (
    input  wire logic [15:0] value,
    input  wire logic [3:0]  bit_position_field,
    input  wire logic        byte_op,
    output logic      [15:0] result
);
    // ----------------------------------------------------------------
    // mask
    // ----------------------------------------------------------------
    // byte mode keeps position within 0..7, upper byte untouched
    wire logic [3:0]  pos  = byte_op ? {1'b0, bit_position_field[2:0]} : bit_position_field; // RULE3
    wire logic [15:0] mask = 16'h0001 << pos;
    assign result = value & ~mask; // RULE1
endmodule

// ===== rtl/bcb_ptr_upd.sv
`timescale 1ns/10ps
module bcb_ptr_upd (
    input  wire logic [15:0]           ptr,
    input  wire bcb_pkg::bcb_amode_type mode,
    input  wire logic                  byte_op,
    output logic      [15:0]           ea,
    output logic      [15:0]           next_ptr,
    output logic                       writes
);
    // ----------------------------------------------------------------
    // address generation
    // ----------------------------------------------------------------
    wire logic [15:0] step = byte_op ? 16'h0001 : 16'h0002; // RULE18
    wire logic [15:0] inc  = ptr + step;
    wire logic [15:0] dec  = ptr - step;
    wire logic        pre  = (mode == bcb_pkg::BCB_AM_PREINC) || (mode == bcb_pkg::BCB_AM_PREDEC);
    wire logic        up   = (mode == bcb_pkg::BCB_AM_PREINC) || (mode == bcb_pkg::BCB_AM_POSTINC);
    assign writes   = pre || (mode == bcb_pkg::BCB_AM_POSTINC) || (mode == bcb_pkg::BCB_AM_POSTDEC);
    assign next_ptr = up ? inc : dec;
    assign ea       = pre ? next_ptr : ptr; // RULE6
endmodule

// ===== rtl/bcb_exec.sv
`timescale 1ns/10ps
`include "bcb_cfg.svh"
module bcb_exec #(
    parameter logic ENHANCED = 1'b0
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     instr_valid,
    input  wire logic [23:0]              instr,
    input  wire logic [22:0]              pc,
    input  wire logic                     carry,
    input  wire logic [7:0]               extended_data_page_register,
    input  wire logic [15:0]              wreg_rdata,
    input  wire logic [15:0]              mem_rdata,
    output logic      [3:0]               wreg_rsel,
    output bcb_pkg::bcb_mem_req_type      mem_req,
    output bcb_pkg::bcb_wreg_wr_type      wreg_wr,
    output bcb_pkg::bcb_wreg_wr_type      ptr_wr,
    output logic                          pc_load,
    output logic      [22:0]              pc_target,
    output logic                          nop_insert,
    output logic                          busy,
    output logic                          flags_we
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BCB_ST_IDLE = 2'b00,
        BCB_ST_NOP  = 2'b01
    } bcb_state_type;

    function automatic logic op_is(input logic [23:0] w, input logic [7:0] op);
        op_is = (w[23:16] == op);
    endfunction

    wire logic is_fbclr = instr_valid && !busy && op_is(instr, `BCB_OP_FBCLR); // RULE1
    wire logic is_wbclr = instr_valid && !busy && op_is(instr, `BCB_OP_WBCLR); // RULE5
    wire logic is_bra   = instr_valid && !busy && op_is(instr, `BCB_OP_BRA);   // RULE9
    wire logic is_brac  = instr_valid && !busy && op_is(instr, `BCB_OP_BRAC);  // RULE14
    wire logic [19:0] cbr_pat = ENHANCED ? `BCB_OP_CBR_ENH : `BCB_OP_CBR_ORIG;
    wire logic is_cbr   = instr_valid && !busy && (instr[23:4] == cbr_pat);    // RULE13

    // file form: bbbf ffff ffff fffb, bit field is b[3:1] then lsb
    wire logic [3:0]  f_bit   = {instr[15:13], instr[0]};
    wire logic [12:0] f_addr  = {instr[12:1], 1'b0} & `BCB_FADDR_MAX;
    wire logic [12:0] f_addrb = instr[12:0] & `BCB_FADDR_MAX;
    // .B for file form carried in bit 14 of the encoding
    wire logic        f_byte  = instr[14];
    // register form: bbbb 0B00 0ppp ssss
    wire logic [3:0]  bit_position_field = is_fbclr ? f_bit : instr[15:12];
    wire logic        w_byte  = instr[10];
    wire bcb_pkg::bcb_amode_type amode = bcb_pkg::bcb_amode_type'(instr[6:4]);
    wire logic [3:0]  source_work_register = instr[3:0];
    wire logic [3:0]  offset_work_register = instr[3:0];
    wire logic        byte_op = is_fbclr ? f_byte : w_byte; // RULE5
    wire logic        direct  = (amode == bcb_pkg::BCB_AM_DIRECT);

    // ----------------------------------------------------------------
    // operand paths
    // ----------------------------------------------------------------
    logic [15:0] clr_in;
    logic [15:0] clr_out;
    logic [15:0] ea;
    logic [15:0] next_ptr;
    logic        ptr_writes;

    bcb_ptr_upd u_ptr (
        .ptr      (wreg_rdata),
        .mode     (amode),
        .byte_op  (byte_op),
        .ea       (ea),
        .next_ptr (next_ptr),
        .writes   (ptr_writes)
    );

    assign clr_in = (is_wbclr && direct) ? wreg_rdata : mem_rdata;

    bcb_bit_clr u_clr (
        .value              (clr_in),
        .bit_position_field (bit_position_field),
        .byte_op            (byte_op),
        .result             (clr_out)
    );

    // enhanced core prefixes the page for indirect accesses
    wire logic [23:0] ind_addr = ENHANCED ? {extended_data_page_register, ea}
                                          : {8'h00, ea}; // RULE7
    wire logic [23:0] f_full   = {11'h000, f_byte ? f_addrb : f_addr}; // RULE2

    assign wreg_rsel = source_work_register;

    // single cycle read-modify-write; memory read data is combinational
    always_comb begin
        mem_req       = '0;
        mem_req.rd    = is_fbclr || (is_wbclr && !direct);
        mem_req.wr    = mem_req.rd; // RULE8
        mem_req.addr  = is_fbclr ? f_full : ind_addr;
        mem_req.byte_op = byte_op;
        mem_req.wdata = clr_out; // RULE1
        wreg_wr       = '0;
        wreg_wr.we    = is_wbclr && direct;
        wreg_wr.sel   = source_work_register;
        wreg_wr.data  = clr_out;
        ptr_wr        = '0;
        ptr_wr.we     = is_wbclr && !direct && ptr_writes; // RULE18
        ptr_wr.sel    = source_work_register;
        ptr_wr.data   = next_ptr;
    end

    assign flags_we = 1'b0; // RULE1 RULE5

    // ----------------------------------------------------------------
    // branch targets
    // ----------------------------------------------------------------
    wire logic [22:0] pc_next = pc + 23'h000002;
    // offset words doubled, sign kept across 17 bits and beyond
    wire logic [22:0] lit_off = {{6{instr[15]}}, instr[15:0], 1'b0};  // RULE10 RULE16
    wire logic [22:0] reg_off = {{6{wreg_rdata[15]}}, wreg_rdata, 1'b0}; // RULE12
    wire logic        take_lit = is_bra || (is_brac && carry); // RULE14
    wire logic        taken    = take_lit || is_cbr;
    wire logic [2:0]  br_cyc   = ENHANCED ? `BCB_BR_CYC_ENH : `BCB_BR_CYC_ORIG; // RULE11

    assign pc_load   = taken;
    assign pc_target = pc_next + (is_cbr ? reg_off : lit_off); // RULE9 RULE12

    // ----------------------------------------------------------------
    // flush sequencer
    // ----------------------------------------------------------------
    // the already fetched word is replaced by nops for the extra cycles
    bcb_state_type state;
    bcb_state_type next_state;
    logic [2:0]    left;
    logic [2:0]    next_left;

    always_comb begin
        next_state = state;
        next_left  = left;
        unique case (state)
            BCB_ST_IDLE: begin
                if (taken) begin
                    next_state = BCB_ST_NOP; // RULE15
                    next_left  = br_cyc - 3'h1; // RULE17
                end
            end
            BCB_ST_NOP: begin
                next_left = left - 3'h1;
                if (left == 3'h1) begin
                    next_state = BCB_ST_IDLE;
                end
            end
            default: begin
                next_state = BCB_ST_IDLE;
            end
        endcase
    end

    // state and counter
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state <= BCB_ST_IDLE;
            left  <= 3'h0;
        end else begin
            state <= next_state;
            left  <= next_left;
        end
    end

    assign busy       = (state == BCB_ST_NOP);
    assign nop_insert = busy; // RULE12 RULE15

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // plain constant so the delay below stays a fixed count per variant
    localparam int NOP_GAP = ENHANCED ? 3 : 1;
    int unsigned nop_run;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !busy) begin
            nop_run <= 0;
        end else begin
            nop_run <= nop_run + 1;
        end
    end

    bra_cycles_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
        is_bra |=> busy [*1] ##0 (nop_run == 0))
        else $error("relative branch did not start nop cycles");
    nop_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
        nop_run <= 32'(br_cyc) - 1)
        else $error("nop run too long");
    nop_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
        $rose(busy) |-> busy [*1] ##NOP_GAP !busy)
        else $error("taken branch nop count wrong");
    carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
        is_brac && !carry |-> !pc_load ##1 !busy)
        else $error("carry branch taken without carry");
    target_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
        is_bra |-> pc_target == pc + 23'h2 + {{6{instr[15]}}, instr[15:0], 1'b0})
        else $error("relative branch target wrong");
    cbr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
        is_cbr |-> pc_load && pc_target[0] == 1'b0 ##1 nop_insert)
        else $error("computed branch wrong");
    fclr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        is_fbclr |-> mem_req.wr && !flags_we && (mem_req.wdata[bit_position_field] == 1'b0))
        else $error("file bit not cleared");
    wclr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        is_wbclr && direct |-> wreg_wr.we && !busy && (wreg_wr.data | clr_in) == clr_in)
        else $error("register bit clear wrong");
    step_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE18
        ptr_wr.we && amode == bcb_pkg::BCB_AM_POSTINC |->
            ptr_wr.data == wreg_rdata + (byte_op ? 16'h1 : 16'h2))
        else $error("pointer step wrong");

    bra_c: cover property (@(posedge ref_clk) is_bra);
    brac_c: cover property (@(posedge ref_clk) is_brac && carry);
    cbr_c: cover property (@(posedge ref_clk) is_cbr);
    ind_c: cover property (@(posedge ref_clk) ptr_wr.we);
endmodule

// ===== test/bit_clear_and_branch_exec_tb_top.sv
`timescale 1ns/10ps
module bit_clear_and_branch_exec_tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                     ref_clk;
    logic                     rst_n;
    logic                     instr_valid;
    logic [23:0]              instr;
    logic [22:0]              pc;
    logic                     carry;
    logic [7:0]               page;
    logic [15:0]              wreg_rdata;
    logic [15:0]              mem_rdata;
    logic [3:0]               wreg_rsel;
    bcb_pkg::bcb_mem_req_type mem_req;
    bcb_pkg::bcb_wreg_wr_type wreg_wr;
    bcb_pkg::bcb_wreg_wr_type ptr_wr;
    logic                     pc_load;
    logic [22:0]              pc_target;
    logic                     nop_insert;
    logic                     busy;
    logic                     flags_we;
    int                       err_total;
    int                       checked;

    bcb_exec #(.ENHANCED(1'b0)) u_dut (
        .ref_clk                     (ref_clk),
        .rst_n                       (rst_n),
        .instr_valid                 (instr_valid),
        .instr                       (instr),
        .pc                          (pc),
        .carry                       (carry),
        .extended_data_page_register (page),
        .wreg_rdata                  (wreg_rdata),
        .mem_rdata                   (mem_rdata),
        .wreg_rsel                   (wreg_rsel),
        .mem_req                     (mem_req),
        .wreg_wr                     (wreg_wr),
        .ptr_wr                      (ptr_wr),
        .pc_load                     (pc_load),
        .pc_target                   (pc_target),
        .nop_insert                  (nop_insert),
        .busy                        (busy),
        .flags_we                    (flags_we)
    );

    // 10 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // inputs change 1 ns after the edge; outputs are combinational, so look 1 ns later
    task automatic drive(input logic [23:0] i, input logic v, input logic [15:0] w,
                         input logic [15:0] m, input logic [22:0] p, input logic c);
        @(posedge ref_clk);
        #1;
        instr = i;
        instr_valid = v;
        wreg_rdata = w;
        mem_rdata = m;
        pc = p;
        carry = c;
        #1;
    endtask

    // counts the issuing cycle plus every busy cycle that follows it
    task automatic wait_idle(input int exp);
        int n;
        n = 1;
        drive(24'h000000, 1'b0, wreg_rdata, mem_rdata, pc, carry);
        while (busy === 1'b1 && n < 16) begin
            n++;
            drive(24'h000000, 1'b0, wreg_rdata, mem_rdata, pc, carry);
        end
        if (n >= 16) begin
            err_total++;
            report_and_stop();
        end
        chk(n, exp);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic file_clear();
        drive(24'ha98401, 1'b1, 16'h0000, 16'haa55, 23'h000100, 1'b1);
        chk(mem_req.wr, 1'b1);
        chk(mem_req.addr, 24'h000400);
        chk(mem_req.wdata, 16'ha855);
        chk(flags_we, 1'b0);
        wait_idle(1);
        // top even word address, bit 0
        drive(24'ha91ffe, 1'b1, 16'h0000, 16'h0001, 23'h000100, 1'b1);
        chk(mem_req.addr, 24'h001ffe);
        chk(mem_req.wdata, 16'h0000);
        drive(24'ha98401, 1'b0, 16'h0000, 16'haa55, 23'h000100, 1'b1);
        chk(mem_req.wr, 1'b0);
    endtask

    task automatic reg_direct();
        drive(24'ha12402, 1'b1, 16'hf234, 16'h0000, 23'h000100, 1'b0);
        chk(wreg_rsel, 4'h2);
        chk({wreg_wr.we, wreg_wr.sel}, 5'h12);
        chk(wreg_wr.data, 16'hf230);
        chk(mem_req.wr, 1'b0);
        drive(24'ha1f005, 1'b1, 16'hffff, 16'h0000, 23'h000100, 1'b0);
        chk(wreg_wr.data, 16'h7fff);
        chk(flags_we, 1'b0);
    endtask

    // every indirect mode, both widths, pointer 0x0100 in register 6
    task automatic reg_indirect();
        logic [15:0] step;
        logic [15:0] ea;
        logic [15:0] nx;
        for (int m = 1; m <= 5; m++) begin
            for (int b = 0; b < 2; b++) begin
                step = (b == 1) ? 16'h0001 : 16'h0002;
                ea = (m == 4) ? 16'h0100 - step : (m == 5) ? 16'h0100 + step : 16'h0100;
                nx = (m == 2 || m == 4) ? 16'h0100 - step : 16'h0100 + step;
                drive({8'ha1, 4'h0, 1'b0, b[0], 2'b00, 1'b0, m[2:0], 4'h6}, 1'b1,
                      16'h0100, 16'hffff, 23'h000100, 1'b0);
                chk(mem_req.wr, 1'b1);
                chk(mem_req.addr[15:0], ea);
                chk(ptr_wr.we, m != 1);
                if (m != 1) begin
                    chk({ptr_wr.sel, ptr_wr.data}, {4'h6, nx});
                end
                if (b == 0) begin
                    chk(mem_req.wdata, 16'hfffe);
                end
            end
        end
    endtask

    task automatic branches();
        drive(24'h370004, 1'b1, 16'h0000, 16'h0000, 23'h002000, 1'b0);
        chk({pc_load, pc_target}, {1'b1, 23'h00200a});
        // a word offered in the extra cycle is ignored
        drive(24'h370004, 1'b1, 16'h0000, 16'h0000, 23'h002000, 1'b0);
        chk({busy, nop_insert, pc_load}, 3'h6);
        wait_idle(1);
        drive(24'h378000, 1'b1, 16'h0000, 16'h0000, 23'h010000, 1'b0);
        chk(pc_target, 23'h000002);
        wait_idle(2);
        drive(24'h377fff, 1'b1, 16'h0000, 16'h0000, 23'h000000, 1'b0);
        chk(pc_target, 23'h010000);
        wait_idle(2);
        drive(24'h016003, 1'b1, 16'h0084, 16'h0000, 23'h002000, 1'b0);
        chk({wreg_rsel, pc_load}, 5'h07);
        chk(pc_target, 23'h00210a);
        wait_idle(2);
        drive(24'h01600f, 1'b1, 16'hfffe, 16'h0000, 23'h002000, 1'b0);
        chk(pc_target, 23'h001ffe);
        wait_idle(2);
        drive(24'h010603, 1'b1, 16'h0084, 16'h0000, 23'h002000, 1'b0);
        chk(pc_load, 1'b0);
        wait_idle(1);
    endtask

    task automatic carry_branch();
        drive(24'h310003, 1'b1, 16'h0000, 16'h0000, 23'h002000, 1'b1);
        chk({pc_load, pc_target}, {1'b1, 23'h002008});
        wait_idle(2);
        drive(24'h31fffb, 1'b1, 16'h0000, 16'h0000, 23'h00623c, 1'b1);
        chk(pc_target, 23'h006234);
        drive(24'h000000, 1'b0, 16'h0000, 16'h0000, 23'h00623c, 1'b1);
        chk({busy, nop_insert}, 2'h3);
        // already inside the single nop cycle, so only this cycle remains
        wait_idle(1);
        drive(24'h310003, 1'b1, 16'h0000, 16'h0000, 23'h002000, 1'b0);
        chk(pc_load, 1'b0);
        wait_idle(1);
        drive(24'hffffff, 1'b1, 16'h0000, 16'h0000, 23'h002000, 1'b1);
        chk({pc_load, mem_req.wr, wreg_wr.we, ptr_wr.we}, 4'h0);
        wait_idle(1);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        err_total = 0;
        checked = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 24'h000000;
        pc = 23'h000000;
        carry = 1'b0;
        page = 8'h00;
        wreg_rdata = 16'h0000;
        mem_rdata = 16'h0000;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        file_clear();
        reg_direct();
        reg_indirect();
        branches();
        carry_branch();
        report_and_stop();
    end
endmodule
